/* File: logic/ldo_status_params.svh */
// register offsets, field positions and reset values for the status and mask block
// assumes nothing; definitions only
`ifndef LDO_STATUS_PARAMS_SVH
`define LDO_STATUS_PARAMS_SVH
`define LIN_REG_STATUS_ADDR 8'h1F
`define TOP_IRQ_MASK_FIRST_ADDR 8'h20
`define TOP_IRQ_MASK_SECOND_ADDR 8'h21
`define LIN_REG_EVENT_ADDR 8'h1C
`define TOP_EVENT_ADDR 8'h1A
`define TOP_STATE_ADDR 8'h1D
`define LIN_REG_STATUS_RESET 8'h00
`define TOP_STATE_RESET 8'h00
`define EVENT_RESET 8'h00
`define FIRST_MASK_USED 8'h95
`define SECOND_MASK_USED 8'h01
`define LR_ENABLED1_BIT 7
`define LR_INVALID1_BIT 6
`define LR_LIMITED1_BIT 4
`define LR_ENABLED0_BIT 3
`define LR_INVALID0_BIT 2
`define LR_LIMITED0_BIT 0
`define PG_BLOCK_BIT 7
`define SYNC_BLOCK_BIT 4
`define THERM_BLOCK_BIT 2
`define MEAS_BLOCK_BIT 0
`define RESET_BLOCK_BIT 0
`define TOP_EV_PG_BIT 7
`define TOP_EV_SYNC_BIT 4
`define TOP_EV_THERM_BIT 2
`define TOP_EV_MEAS_BIT 0
`define TOP_EV_RESET_BIT 1
`define TOP_ST_PG_BIT 7
`define TOP_ST_SYNC_BIT 4
`define TOP_ST_THERM_BIT 2
`endif

/* File: logic/ldo_status_pkg.sv */
// types shared by the status and mask block
// assumes the params header for bit positions
package ldo_status_pkg;
    typedef struct packed {
        logic lin_reg1_enabled;
        logic lin_reg1_voltage_invalid;
        logic lin_reg1_current_limited;
        logic lin_reg0_enabled;
        logic lin_reg0_voltage_invalid;
        logic lin_reg0_current_limited;
    } lin_reg_raw_t;
    typedef struct packed {
        logic power_good_pin_state;
        logic sync_clk_invalid;
        logic thermal_warn_state;
    } top_raw_t;
    typedef struct packed {
        logic power_good_pin_event;
        logic sync_clk_event;
        logic thermal_warn_event;
        logic load_meas_ready_event;
        logic reg_reset_event;
    } top_events_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage : ldo_status_pkg

/* File: logic/sync_2ff.sv */
// two flip-flop synchroniser for a vector of pin levels
// assumes inputs asynchronous to core_clk_i
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule : sync_2ff

/* File: logic/ldo_status_top.sv */
// linear regulator status, top event flags and interrupt masks
// assumes a register request port already decoded from the serial interface
//
// Overview of operation
// - enable state of regulator 1 on bit 7, regulator 0 on bit 3
// - unlatched voltage invalid on bit 6 and bit 2, 1 means invalid
// - unlatched current limit on bit 4 and bit 0, 1 means limiting
// - first mask bit 7 blocks the power-good pin interrupt
// - power-good mask leaves the power-good state bit live
// - first mask bit 4 blocks the sync clock detection interrupt
// - sync clock mask leaves the clock validity state bit live
// - first mask bit 2 blocks the thermal warning interrupt
// - thermal mask leaves the thermal warning state bit live
// - first mask bit 0 blocks the load measurement ready interrupt
// - second mask bit 0 blocks the register reset interrupt, rest reserved
// - host writes to the reset mask bit are ignored
// - regulator event flags latch until host writes 1 to them
// - top power-good state bit follows the power-good pin
`timescale 1ns/1ps
`include "ldo_status_params.svh"
module ldo_status_top (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [5:0] lin_reg_raw_i,
    input wire logic [2:0] top_raw_i,
    input wire logic [5:0] lin_reg_event_i,
    input wire logic [3:0] top_event_i,
    input wire logic [7:0] nv_mask_first_i,
    input wire logic nv_mask_second_i,
    input wire ldo_status_pkg::reg_req_t req_i,
    output logic [7:0] rdata_o,
    output logic irq_o
);
    // ---------------------------------------------------------------
    // pin synchronisation
    // ---------------------------------------------------------------
    logic [8:0] raw_sync;
    sync_2ff #(.WIDTH(9)) sync_2ff_i (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i({lin_reg_raw_i, top_raw_i}),
        .sync_o(raw_sync)
    );
    ldo_status_pkg::lin_reg_raw_t lr;
    ldo_status_pkg::top_raw_t tr;
    assign lr = raw_sync[8:3];
    assign tr = raw_sync[2:0];

    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                        input logic clr, input logic [7:0] wd);
        // set wins over a clear in the same cycle
        w1c = (cur & ~(clr ? wd : 8'h00)) | set;
    endfunction : w1c

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] mask1_q, mask1_d;
    logic mask2_q, mask2_d;
    logic [7:0] lr_ev_q, lr_ev_d;
    logic [7:0] top_ev_q, top_ev_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic load_q, load_d;
    logic [7:0] lr_stat, top_stat, lr_set, top_set;

    always_comb begin
        lr_stat = `LIN_REG_STATUS_RESET;
        lr_stat[`LR_ENABLED1_BIT] = lr.lin_reg1_enabled;
        lr_stat[`LR_ENABLED0_BIT] = lr.lin_reg0_enabled;
        lr_stat[`LR_INVALID1_BIT] = lr.lin_reg1_voltage_invalid;
        lr_stat[`LR_INVALID0_BIT] = lr.lin_reg0_voltage_invalid;
        lr_stat[`LR_LIMITED1_BIT] = lr.lin_reg1_current_limited;
        lr_stat[`LR_LIMITED0_BIT] = lr.lin_reg0_current_limited;
        // state bits never look at the masks
        top_stat = `TOP_STATE_RESET;
        top_stat[`TOP_ST_PG_BIT] = tr.power_good_pin_state;
        top_stat[`TOP_ST_SYNC_BIT] = tr.sync_clk_invalid;
        top_stat[`TOP_ST_THERM_BIT] = tr.thermal_warn_state;
        lr_set = {1'b0, lin_reg_event_i[5:3], 1'b0, lin_reg_event_i[2:0]};
        top_set = {top_event_i[3], 2'b00, top_event_i[2], 1'b0, top_event_i[1],
                   load_q, top_event_i[0]};
    end

    always_comb begin
        mask1_d = mask1_q;
        mask2_d = mask2_q;
        load_d = 1'b0;
        if (load_q) begin
            mask1_d = nv_mask_first_i & `FIRST_MASK_USED;
            mask2_d = nv_mask_second_i;
        end else if (req_i.wr && req_i.addr == `TOP_IRQ_MASK_FIRST_ADDR) begin
            mask1_d = req_i.wdata & `FIRST_MASK_USED;
        end
        lr_ev_d = w1c(lr_ev_q, lr_set, req_i.wr && req_i.addr == `LIN_REG_EVENT_ADDR,
                      req_i.wdata);
        top_ev_d = w1c(top_ev_q, top_set, req_i.wr && req_i.addr == `TOP_EVENT_ADDR,
                       req_i.wdata);
        rdata_d = rdata_q;
        if (req_i.rd) begin
            unique case (req_i.addr)
                `LIN_REG_STATUS_ADDR: rdata_d = lr_stat;
                `TOP_IRQ_MASK_FIRST_ADDR: rdata_d = mask1_q;
                `TOP_IRQ_MASK_SECOND_ADDR: rdata_d = {7'h00, mask2_q};
                `LIN_REG_EVENT_ADDR: rdata_d = lr_ev_q;
                `TOP_EVENT_ADDR: rdata_d = top_ev_q;
                `TOP_STATE_ADDR: rdata_d = top_stat;
                default: rdata_d = 8'h00;
            endcase
        end
        irq_d = (|lr_ev_q)
              | (top_ev_q[`TOP_EV_PG_BIT] & ~mask1_q[`PG_BLOCK_BIT])
              | (top_ev_q[`TOP_EV_SYNC_BIT] & ~mask1_q[`SYNC_BLOCK_BIT])
              | (top_ev_q[`TOP_EV_THERM_BIT] & ~mask1_q[`THERM_BLOCK_BIT])
              | (top_ev_q[`TOP_EV_MEAS_BIT] & ~mask1_q[`MEAS_BLOCK_BIT])
              | (top_ev_q[`TOP_EV_RESET_BIT] & ~mask2_q);
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask1_q <= 8'h00;
            mask2_q <= 1'b0;
            lr_ev_q <= `EVENT_RESET;
            top_ev_q <= `EVENT_RESET;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
            load_q <= 1'b1;
        end else begin
            mask1_q <= mask1_d;
            mask2_q <= mask2_d;
            lr_ev_q <= lr_ev_d;
            top_ev_q <= top_ev_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            load_q <= load_d;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = irq_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    status_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == `LIN_REG_STATUS_ADDR
        |=> rdata_o[7] == $past(lr.lin_reg1_enabled))
        else $error("enable status read wrong");
    invalid_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == `LIN_REG_STATUS_ADDR
        |=> rdata_o[2] == $past(lr.lin_reg0_voltage_invalid))
        else $error("voltage invalid read wrong");
    limit_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == `LIN_REG_STATUS_ADDR
        |=> rdata_o[4] == $past(lr.lin_reg1_current_limited))
        else $error("current limit read wrong");
    pg_masked_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        mask1_q[7] && !(|lr_ev_q) && top_ev_q == 8'h80 |=> !irq_o)
        else $error("masked power-good raised irq");
    pg_state_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == `TOP_STATE_ADDR |=> rdata_o[7] == $past(tr.power_good_pin_state))
        else $error("power-good state wrong");
    reset_mask_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !load_q |=> mask2_q == $past(mask2_q))
        else $error("reset mask changed by write");
    event_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        lr_ev_q[0] && !(req_i.wr && req_i.addr == `LIN_REG_EVENT_ADDR) |=> lr_ev_q[0])
        else $error("event flag dropped");
    irq_level_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (|lr_ev_q) |=> irq_o)
        else $error("irq missing");
    // masked flags stay latched and readable, only the irq term drops
    pg_unmasked_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        top_ev_q[`TOP_EV_PG_BIT] && !mask1_q[`PG_BLOCK_BIT] |=> irq_o)
        else $error("unmasked power-good gave no irq");
    sync_masked_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        mask1_q[`SYNC_BLOCK_BIT] && !(|lr_ev_q) && top_ev_q == 8'h10 |=> !irq_o)
        else $error("masked sync clock raised irq");
    sync_unmasked_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        top_ev_q[`TOP_EV_SYNC_BIT] && !mask1_q[`SYNC_BLOCK_BIT] |=> irq_o)
        else $error("unmasked sync clock gave no irq");
    therm_masked_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        mask1_q[`THERM_BLOCK_BIT] && !(|lr_ev_q) && top_ev_q == 8'h04 |=> !irq_o)
        else $error("masked thermal warning raised irq");
    therm_unmasked_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        top_ev_q[`TOP_EV_THERM_BIT] && !mask1_q[`THERM_BLOCK_BIT] |=> irq_o)
        else $error("unmasked thermal warning gave no irq");
    meas_masked_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        mask1_q[`MEAS_BLOCK_BIT] && !(|lr_ev_q) && top_ev_q == 8'h01 |=> !irq_o)
        else $error("masked measurement ready raised irq");
    meas_unmasked_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        top_ev_q[`TOP_EV_MEAS_BIT] && !mask1_q[`MEAS_BLOCK_BIT] |=> irq_o)
        else $error("unmasked measurement ready gave no irq");
    reset_masked_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        mask2_q && !(|lr_ev_q) && top_ev_q == 8'h02 |=> !irq_o)
        else $error("masked register reset raised irq");
    reset_unmasked_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        top_ev_q[`TOP_EV_RESET_BIT] && !mask2_q |=> irq_o)
        else $error("unmasked register reset gave no irq");
    reset_event_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        load_q |=> top_ev_q[`TOP_EV_RESET_BIT])
        else $error("register reset event not set");
    // the nonvolatile copy is the only source of the reset mask
    mask_load_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        load_q |=> mask1_q == ($past(nv_mask_first_i) & `FIRST_MASK_USED))
        else $error("first mask not loaded");
    mask2_load_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        load_q |=> mask2_q == $past(nv_mask_second_i))
        else $error("second mask not loaded");
    sync_state_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == `TOP_STATE_ADDR
        |=> rdata_o[`TOP_ST_SYNC_BIT] == $past(tr.sync_clk_invalid))
        else $error("sync clock state wrong");
    therm_state_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == `TOP_STATE_ADDR
        |=> rdata_o[`TOP_ST_THERM_BIT] == $past(tr.thermal_warn_state))
        else $error("thermal warning state wrong");
    enable0_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == `LIN_REG_STATUS_ADDR
        |=> rdata_o[3] == $past(lr.lin_reg0_enabled))
        else $error("regulator 0 enable read wrong");
    flag_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        lr_ev_q[0] && req_i.wr && req_i.addr == `LIN_REG_EVENT_ADDR
        && req_i.wdata[0] && !lin_reg_event_i[0] |=> !lr_ev_q[0])
        else $error("event flag not cleared");
    set_wins_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        lin_reg_event_i[0] |=> lr_ev_q[0])
        else $error("event flag not latched");
endmodule : ldo_status_top

/* File: bench/ldo_status_and_top_irq_masks_tb.sv */
// self-checking bench for the regulator status and interrupt mask block
// assumes the register request port and pin levels are driven directly by the bench
`timescale 1ns/1ps
`include "ldo_status_params.svh"
module ldo_status_and_top_irq_masks_tb;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [5:0] lin_reg_raw_i = '0;
    logic [2:0] top_raw_i = '0;
    logic [5:0] lin_reg_event_i = '0;
    logic [3:0] top_event_i = '0;
    logic [7:0] nv_mask_first_i = 8'hFF;
    logic nv_mask_second_i = 1'b0;
    ldo_status_pkg::reg_req_t req_i = '0;
    logic [7:0] rdata_o;
    logic irq_o;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    ldo_status_top ldo_status_top_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .lin_reg_raw_i(lin_reg_raw_i), .top_raw_i(top_raw_i),
        .lin_reg_event_i(lin_reg_event_i), .top_event_i(top_event_i),
        .nv_mask_first_i(nv_mask_first_i), .nv_mask_second_i(nv_mask_second_i),
        .req_i(req_i), .rdata_o(rdata_o), .irq_o(irq_o));
    // ----------------------------------------
    // clock, timeout and shared tasks
    // ----------------------------------------
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    task automatic end_sim();
        if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // whole run needs well under a thousand cycles
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i) req_i = {2'b10, a, d};
        @(negedge core_clk_i) req_i = '0;
    endtask : wr
    // read data is registered on the request edge, so it is settled one half cycle later
    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk_i) req_i = {2'b01, a, 8'h00};
        @(negedge core_clk_i) req_i = '0;
        check(nm, e, rdata_o);
    endtask : rchk
    task automatic do_reset(input logic [7:0] nv1, input logic nv2);
        rst_i = 1'b1;
        nv_mask_first_i = nv1;
        nv_mask_second_i = nv2;
        idle(2);
        rst_i = 1'b0;
        idle(3);
    endtask : do_reset
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_start();
        rchk("mask1 after reset", 8'h20, 8'h95);
        rchk("mask2 after reset", 8'h21, 8'h00);
        check("irq reset event", 8'h01, {7'h0, irq_o});
        rchk("top events", 8'h1A, 8'h02);
        wr(8'h20, 8'hFF);
        rchk("mask1 reserved", 8'h20, 8'h95);
        wr(8'h1A, 8'h02);
        idle(2);
        check("irq cleared", 8'h00, {7'h0, irq_o});
    endtask : t_reset_start
    task automatic t_state();
        logic [7:0] m [3] = '{8'h04, 8'h10, 8'h80};
        for (int i = 0; i < 3; i++) begin
            @(negedge core_clk_i) top_raw_i = 3'h1 << i;
            idle(4);
            rchk("top state", 8'h1D, m[i]);
        end
        top_raw_i = '0;
        idle(4);
        rchk("top state idle", 8'h1D, 8'h00);
    endtask : t_state
    task automatic t_status();
        logic [7:0] m [6] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80};
        for (int i = 0; i < 6; i++) begin
            @(negedge core_clk_i) lin_reg_raw_i = 6'h01 << i;
            idle(4);
            rchk("lin status", 8'h1F, m[i]);
        end
        lin_reg_raw_i = 6'h3F;
        idle(4);
        wr(8'h1F, 8'h00);
        rchk("lin status all", 8'h1F, 8'hDD);
    endtask : t_status
    task automatic t_top_irq();
        logic [7:0] m [4] = '{8'h01, 8'h04, 8'h10, 8'h80};
        for (int i = 0; i < 4; i++) begin
            wr(8'h20, 8'h95);
            @(negedge core_clk_i) top_event_i = 4'h1 << i;
            @(negedge core_clk_i) top_event_i = '0;
            idle(2);
            check("irq masked", 8'h00, {7'h0, irq_o});
            wr(8'h1A, 8'hFF);
            wr(8'h20, 8'h95 ^ m[i]);
            @(negedge core_clk_i) top_event_i = 4'h1 << i;
            @(negedge core_clk_i) top_event_i = '0;
            idle(2);
            check("irq unmasked", 8'h01, {7'h0, irq_o});
            rchk("top event flag", 8'h1A, m[i]);
            wr(8'h1A, m[i]);
            idle(2);
            check("irq after clear", 8'h00, {7'h0, irq_o});
        end
    endtask : t_top_irq
    task automatic t_lin();
        logic [7:0] m [6] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h20, 8'h40};
        for (int i = 0; i < 6; i++) begin
            @(negedge core_clk_i) lin_reg_event_i = 6'h01 << i;
            @(negedge core_clk_i) lin_reg_event_i = '0;
            wr(8'h1C, ~m[i]);
            idle(2);
            check("irq lin event", 8'h01, {7'h0, irq_o});
            rchk("lin event held", 8'h1C, m[i]);
            wr(8'h1C, m[i]);
            idle(2);
            check("irq lin clear", 8'h00, {7'h0, irq_o});
        end
    endtask : t_lin
    task automatic t_second_reset();
        do_reset(8'h6A, 1'b1);
        rchk("mask1 nv load", 8'h20, 8'h00);
        rchk("mask2 nv load", 8'h21, 8'h01);
        check("irq reset masked", 8'h00, {7'h0, irq_o});
        wr(8'h21, 8'h00);
        rchk("mask2 write ignored", 8'h21, 8'h01);
        rchk("unmapped", 8'h30, 8'h00);
    endtask : t_second_reset
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        do_reset(8'hFF, 1'b0);
        t_reset_start();
        t_state();
        t_status();
        t_top_irq();
        t_lin();
        t_second_reset();
        end_sim();
    end
endmodule : ldo_status_and_top_irq_masks_tb
